// File: rtl/aic_pkg.sv
/*
  Shared constants, register map and carrier types for the analog input
  conditioning block. Assumes a 100 MHz control clock.
*/
package aic_pkg;
  // ----------------------------------------
  // register map (byte addresses, one word each)
  // ----------------------------------------
  localparam int ADR_W = 8;
  localparam logic [ADR_W-1:0] OFS_INPUT_TYPE = 8'h00;
  localparam logic [ADR_W-1:0] OFS_CH1_GAIN = 8'h04;
  localparam logic [ADR_W-1:0] OFS_CH1_BIAS = 8'h08;
  localparam logic [ADR_W-1:0] OFS_CH1_FILT = 8'h0C;
  localparam logic [ADR_W-1:0] OFS_CH2_GAIN = 8'h10;
  localparam logic [ADR_W-1:0] OFS_CH2_BIAS = 8'h14;
  localparam logic [ADR_W-1:0] OFS_CH2_FILT = 8'h18;
  localparam logic [ADR_W-1:0] OFS_CH2_FUNC = 8'h1C;
  localparam logic [ADR_W-1:0] OFS_CH1_OUT = 8'h20;
  localparam logic [ADR_W-1:0] OFS_CH2_OUT = 8'h24;
  localparam logic [ADR_W-1:0] OFS_STATUS = 8'h28;
  localparam logic [3:0] SEL_FULL = 4'hF;

  // ----------------------------------------
  // field layout of the input-type code
  // ----------------------------------------
  localparam int TYPE_CH1_BIPOLAR = 1;
  localparam int TYPE_CH2_LIVEZERO = 0;

  // ----------------------------------------
  // limits and reset values (0.1 % units, 10 ms units)
  // ----------------------------------------
  localparam logic signed [17:0] GAIN_MAX = 18'sh02710;
  localparam logic signed [17:0] BIAS_MIN = -18'sh003E8;
  localparam logic signed [17:0] BIAS1_MAX = 18'sh003E8;
  localparam logic signed [17:0] BIAS2_MAX = 18'sh02710;
  localparam logic [7:0] TAU_MAX = 8'hC8;
  localparam logic [4:0] FUNC_MAX = 5'h11;
  localparam logic [15:0] RST_GAIN = 16'h03E8;
  localparam logic [15:0] RST_BIAS = 16'h0000;
  localparam logic [7:0] RST_TAU = 8'h00;
  localparam logic [1:0] RST_TYPE = 2'h0;

  // ----------------------------------------
  // converter scaling: 12-bit samples, Q12 normalised input
  // ----------------------------------------
  localparam int RAW_W = 12;
  localparam int FRAC = 12;
  localparam logic signed [12:0] LIVE_ZERO_CODE = 13'sh0333;
  localparam int FILT_SHIFT = 8;
  localparam int OUT_W = 18;

  // ----------------------------------------
  // filter timing: one tau unit is 10 ms, split into 2**FILT_SHIFT ticks
  // ----------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int TAU_UNIT_US = 10000;
  localparam int TICK_CYC = (TAU_UNIT_US * CLK_MHZ) / (1 << FILT_SHIFT);
  localparam int TICK_W = 12;

  // ----------------------------------------
  // second channel uses
  // ----------------------------------------
  localparam int NUM_USES = 18;
  typedef enum logic [4:0] {
    USE_AUX_FREQ = 5'h00, USE_FREQ_GAIN = 5'h01, USE_FREQ_BIAS = 5'h02,
    USE_VOLT_BIAS = 5'h03, USE_RAMP_SCALE = 5'h04, USE_DC_BRAKE = 5'h05,
    USE_OVER_TQ = 5'h06, USE_STALL_LVL = 5'h07, USE_LOW_LIMIT = 5'h08,
    USE_JUMP_FREQ = 5'h09, USE_ADD_CH1 = 5'h0A, USE_POS_TQ = 5'h0B,
    USE_NEG_TQ = 5'h0C, USE_REGEN_TQ = 5'h0D, USE_PN_TQ = 5'h0E,
    USE_TQ_CMD_LIM = 5'h0F, USE_TQ_CMD_COMP = 5'h10, USE_PTC = 5'h11
  } aic_use_t;

  typedef struct packed {
    logic [15:0] gain;
    logic signed [15:0] bias;
    logic [7:0] tau;
  } aic_cfg_t;
endpackage

// File: rtl/aic_top.sv
/*
  Analog input conditioning: range decode, gain/bias scaling and a
  first-order low-pass filter for two converted analog channels, plus
  the use selector of the second channel, behind a classic Wishbone slave.
  Assumes both sample inputs are synchronous 12-bit converter codes where
  all-ones is full scale (channel one two's complement when bipolar).
  Assumes the converter front end has already applied the board selector,
  so voltage and current ranges of channel two arrive on the same code
  scale; the selector is only reported back in the status word.
  Assumes the bus master waits for ack and leaves one idle cycle between
  requests; the slave always answers one cycle after it takes a request.
  Values are in 0.1 % units (1000 = 100.0 % of top frequency) and are
  signed, so a negative bias gives negative outputs near the zero point.
  Filter time constants are in 10 ms units; the tick divider runs free,
  so the first filter step after a change lands anywhere within tau ticks.
*/
// Chosen here: the register addresses and the Wishbone register port.
// Operation
// - Input-type codes 0 and 1 make channel one a unipolar 0 to 10 V input.
// - Input-type codes 2 and 3 make channel one a bipolar -10 to +10 V input.
// - Codes 0 and 2 make channel two zero-based, 0-10 V or 0-20 mA by the selector.
// - Codes 1 and 3 make channel two live-zero, 4-20 mA or 2-10 V by the selector.
// - Each channel has its own gain and bias, applied to that channel only.
// - Gain is the output in percent at full-scale input, from 0.0 to 1000.0 percent.
// - Bias is the output at zero point; -100 to 100 percent on one, to 1000 on two.
// - Each channel has its own first-order low-pass filter with its own time constant.
// - The time constant runs from 0.00 to 2.00 s, the time to reach 63 percent of a step.
// - The channel-two use selector accepts codes 0 to 17 only.
// - As auxiliary frequency, channel two full scale means 100 percent of top frequency.
`timescale 1ns/1ps
`default_nettype none
module aic_top
  import aic_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // converted analog inputs
  input wire logic [RAW_W-1:0] analog_channel_one_i,
  input wire logic [RAW_W-1:0] analog_channel_two_i,
  input wire logic voltage_current_selector_i,
  // conditioned values (0.1 % units) and one-hot use flags
  output logic signed [OUT_W-1:0] ch1_value_o,
  output logic signed [OUT_W-1:0] ch2_value_o,
  output logic signed [OUT_W-1:0] aux_freq_o,
  output logic [NUM_USES-1:0] ch2_use_o
);

  // ----------------------------------------
  // register state
  // ----------------------------------------
  logic [1:0] type_q, type_d;
  aic_cfg_t cfg_q [2];
  aic_cfg_t cfg_d [2];
  logic [4:0] func_q, func_d;
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic wr_en;
  logic signed [17:0] wgain, wbias, bias_hi;

  // filter state, one per channel
  logic signed [OUT_W+FILT_SHIFT-1:0] y_q [2];
  logic signed [OUT_W+FILT_SHIFT-1:0] y_d [2];
  logic [7:0] cnt_q [2];
  logic [7:0] cnt_d [2];
  logic [TICK_W-1:0] tick_cnt_q, tick_cnt_d;
  logic tick;
  logic signed [OUT_W-1:0] aux_q, aux_d;
  logic [NUM_USES-1:0] use_q, use_d;

  // ----------------------------------------
  // range decode to a Q12 normalised input
  // ----------------------------------------
  logic signed [FRAC+1:0] x [2];
  logic signed [12:0] lz_diff;
  logic signed [15:0] lz_scaled;

  always_comb begin
    lz_diff = $signed({1'b0, analog_channel_two_i}) - LIVE_ZERO_CODE;
    lz_scaled = (16'(lz_diff) * 16'sh0005) >>> 2;
    if (type_q[TYPE_CH1_BIPOLAR]) begin
      // the sign must come from the code itself: a concatenation is unsigned
      // and would zero-extend, turning negative inputs into large positive ones
      x[0] = 14'($signed({analog_channel_one_i, 1'b0}));
    end else begin
      x[0] = $signed({2'b00, analog_channel_one_i});
    end
    if (!type_q[TYPE_CH2_LIVEZERO]) begin
      x[1] = $signed({2'b00, analog_channel_two_i});
    end else if (lz_diff < 0) begin
      x[1] = '0; // below the live zero reads as the zero point
    end else begin
      x[1] = 14'(lz_scaled);
    end
  end

  // ----------------------------------------
  // filter time base: one tick per 1/256 of a tau unit
  // ----------------------------------------
  always_comb begin
    // the fractional cycle per tick is dropped: tau runs short by well under 0.01 %
    tick = (tick_cnt_q == TICK_W'(TICK_CYC - 1));
    tick_cnt_d = tick ? '0 : tick_cnt_q + 1'b1;
  end

  // ----------------------------------------
  // per-channel scaling and low-pass filter
  // ----------------------------------------
  for (genvar c = 0; c < 2; c++) begin : g_ch
    logic signed [17:0] span;
    logic signed [31:0] prod;
    logic signed [OUT_W-1:0] scaled;
    logic signed [OUT_W+FILT_SHIFT-1:0] target, step;

    always_comb begin
      // bias at zero point, gain at full scale, straight line between
      span = 18'(signed'({2'b00, cfg_q[c].gain})) - 18'(cfg_q[c].bias);
      prod = 32'(span) * 32'(x[c]);
      scaled = 18'(cfg_q[c].bias) + 18'(prod >>> FRAC);
      target = {scaled, {FILT_SHIFT{1'b0}}};
      step = (target - y_q[c]) >>> FILT_SHIFT;
      y_d[c] = y_q[c];
      cnt_d[c] = cnt_q[c];
      if (cfg_q[c].tau == '0) begin
        y_d[c] = target; // zero time constant passes the input straight on
        cnt_d[c] = '0;
      end else if (tick) begin
        // 1/256 of the gap every tau ticks: 63 % after about one tau
        if (cnt_q[c] >= cfg_q[c].tau - 1'b1) begin
          // a gap below one output unit no longer moves y, so a rising input
          // settles up to one unit short of its target
          y_d[c] = y_q[c] + step;
          cnt_d[c] = '0;
        end else begin
          cnt_d[c] = cnt_q[c] + 1'b1;
        end
      end
    end

    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        y_q[c] <= '0;
        cnt_q[c] <= '0;
      end else begin
        y_q[c] <= y_d[c];
        cnt_q[c] <= cnt_d[c];
      end
    end
  end

  // ----------------------------------------
  // second channel use decode
  // ----------------------------------------
  always_comb begin
    use_d = '0;
    // writes above 17 are refused, so the index never leaves the vector
    use_d[func_q] = 1'b1;
    // output unit 1000 = 100.0 % of top frequency, so full scale at reset gain
    aux_d = (aic_use_t'(func_q) == USE_AUX_FREQ) ? y_q[1][OUT_W+FILT_SHIFT-1:FILT_SHIFT] : '0;
  end

  // ----------------------------------------
  // wishbone register access
  // ----------------------------------------
  always_comb begin
    // partial-word writes are ignored to keep limit checks on whole values
    wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && (wb_sel_i == SEL_FULL);
    wgain = signed'({2'b00, wb_dat_i[15:0]});
    wbias = 18'(signed'(wb_dat_i[15:0]));
    bias_hi = (wb_adr_i == OFS_CH1_BIAS) ? BIAS1_MAX : BIAS2_MAX;
    // out-of-range gain and bias values, taken from the low 16 data bits, clamp to the nearest limit instead of being lost,
    // so software that overshoots still lands on a usable setting
    if (wgain > GAIN_MAX) begin
      wgain = GAIN_MAX;
    end
    if (wbias < BIAS_MIN) begin
      wbias = BIAS_MIN;
    end
    if (wbias > bias_hi) begin
      wbias = bias_hi;
    end
    type_d = type_q;
    cfg_d = cfg_q;
    func_d = func_q;
    if (wr_en) begin
      if (wb_adr_i == OFS_INPUT_TYPE) begin
        type_d = wb_dat_i[1:0];
      end else if (wb_adr_i == OFS_CH1_GAIN) begin
        cfg_d[0].gain = wgain[15:0];
      end else if (wb_adr_i == OFS_CH1_BIAS) begin
        cfg_d[0].bias = wbias[15:0];
      end else if (wb_adr_i == OFS_CH1_FILT) begin
        cfg_d[0].tau = (wb_dat_i[7:0] > TAU_MAX) ? TAU_MAX : wb_dat_i[7:0];
      end else if (wb_adr_i == OFS_CH2_GAIN) begin
        cfg_d[1].gain = wgain[15:0];
      end else if (wb_adr_i == OFS_CH2_BIAS) begin
        cfg_d[1].bias = wbias[15:0];
      end else if (wb_adr_i == OFS_CH2_FILT) begin
        cfg_d[1].tau = (wb_dat_i[7:0] > TAU_MAX) ? TAU_MAX : wb_dat_i[7:0];
      end else if (wb_adr_i == OFS_CH2_FUNC) begin
        // out-of-range codes keep the previous use
        if (wb_dat_i[31:5] == '0 && wb_dat_i[4:0] <= FUNC_MAX) begin
          func_d = wb_dat_i[4:0];
        end
      end
    end
  end

  // ----------------------------------------
  // wishbone read data and acknowledge
  // ----------------------------------------
  always_comb begin
    // one ack per request: a strobe held through the ack cycle is not taken twice
    ack_d = wb_cyc_i && wb_stb_i && !ack_q;
    rdat_d = '0;
    if (wb_adr_i == OFS_INPUT_TYPE) begin
      rdat_d[1:0] = type_q;
    end else if (wb_adr_i == OFS_CH1_GAIN) begin
      rdat_d[15:0] = cfg_q[0].gain;
    end else if (wb_adr_i == OFS_CH1_BIAS) begin
      rdat_d = 32'(cfg_q[0].bias);
    end else if (wb_adr_i == OFS_CH1_FILT) begin
      rdat_d[7:0] = cfg_q[0].tau;
    end else if (wb_adr_i == OFS_CH2_GAIN) begin
      rdat_d[15:0] = cfg_q[1].gain;
    end else if (wb_adr_i == OFS_CH2_BIAS) begin
      rdat_d = 32'(cfg_q[1].bias);
    end else if (wb_adr_i == OFS_CH2_FILT) begin
      rdat_d[7:0] = cfg_q[1].tau;
    end else if (wb_adr_i == OFS_CH2_FUNC) begin
      rdat_d[4:0] = func_q;
    end else if (wb_adr_i == OFS_CH1_OUT) begin
      rdat_d = 32'(y_q[0][OUT_W+FILT_SHIFT-1:FILT_SHIFT]);
    end else if (wb_adr_i == OFS_CH2_OUT) begin
      rdat_d = 32'(y_q[1][OUT_W+FILT_SHIFT-1:FILT_SHIFT]);
    end else if (wb_adr_i == OFS_STATUS) begin
      // status: board selector, live-zero flag, bipolar flag
      rdat_d[2:0] = {voltage_current_selector_i, type_q[TYPE_CH2_LIVEZERO],
                     type_q[TYPE_CH1_BIPOLAR]};
    end
    if (!ack_d || wb_we_i) rdat_d = '0;
  end

  // ----------------------------------------
  // state registers, one block per group
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      type_q <= RST_TYPE;
      for (int i = 0; i < 2; i++) begin
        cfg_q[i] <= '{gain: RST_GAIN, bias: RST_BIAS, tau: RST_TAU};
      end
      func_q <= USE_AUX_FREQ;
    end else begin
      type_q <= type_d;
      cfg_q <= cfg_d;
      func_q <= func_d;
    end
  end

  // bus answer: ack and read data stand for exactly one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rdat_q <= '0;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_d;
    end
  end

  // use outputs lag the stored code by one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aux_q <= '0;
      use_q <= '0;
    end else begin
      aux_q <= aux_d;
      use_q <= use_d;
    end
  end

  // ----------------------------------------
  // outputs, all straight from flip-flops
  // ----------------------------------------
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign ch1_value_o = y_q[0][OUT_W+FILT_SHIFT-1:FILT_SHIFT];
  assign ch2_value_o = y_q[1][OUT_W+FILT_SHIFT-1:FILT_SHIFT];
  assign aux_freq_o = aux_q;
  assign ch2_use_o = use_q;

endmodule // aic_top
`default_nettype wire

// File: tb/aic_source_model.sv
/*
  External signal source: drives both converter codes and the board selector.
  Assumes codes are already normalised, 4095 being full scale.
*/
`timescale 1ns/1ps
`default_nettype none
module aic_source_model
  import aic_pkg::*;
(
  // clock
  input wire logic clk_i,
  // requested levels
  input wire logic [RAW_W-1:0] level_one_i,
  input wire logic [RAW_W-1:0] level_two_i,
  input wire logic current_i,
  // converter side
  output logic [RAW_W-1:0] code_one_o,
  output logic [RAW_W-1:0] code_two_o,
  output logic current_o
);
  // one register stands for the conversion delay of a real source
  always_ff @(posedge clk_i) begin
    code_one_o <= level_one_i;
    code_two_o <= level_two_i;
    current_o <= current_i;
  end
endmodule // aic_source_model
`default_nettype wire

// File: tb/aic_top_monitor.sv
/*
  Checker for aic_top bus and output timing.
  Assumes it is bound to aic_top and sees its ports only.
*/
`timescale 1ns/1ps
`default_nettype none
module aic_top_monitor
  import aic_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // values
  input wire logic signed [OUT_W-1:0] ch1_value_o,
  input wire logic signed [OUT_W-1:0] ch2_value_o,
  input wire logic signed [OUT_W-1:0] aux_freq_o,
  input wire logic [NUM_USES-1:0] ch2_use_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_cause_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
  use_onehot_a: assert property (!$past(rst_i) |-> $onehot(ch2_use_o))
    else $error("use not one-hot");
  aux_zero_a: assert property (!ch2_use_o[0] |-> aux_freq_o == '0)
    else $error("aux not zero");
  aux_follow_a: assert property (ch2_use_o[0] |-> aux_freq_o == $past(ch2_value_o))
    else $error("aux not following");
  reset_clear_a: assert property ($past(rst_i) |-> ch1_value_o == '0 && ch2_value_o == '0)
    else $error("values not cleared");
endmodule // aic_top_monitor
bind aic_top aic_top_monitor aic_top_monitor_inst (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .ch1_value_o(ch1_value_o), .ch2_value_o(ch2_value_o), .aux_freq_o(aux_freq_o),
  .ch2_use_o(ch2_use_o));
`default_nettype wire

// File: tb/aic_top_test.sv
/*
  Self-checking bench for aic_top: scaling table, clamps, uses, filter, reset.
  Assumes the source model and the bound checker.
*/
`timescale 1ns/1ps
`default_nettype none
module aic_top_test
  import aic_pkg::*;
;
  typedef struct {
    logic [1:0] ty;
    logic [11:0] c1, c2;
    logic [15:0] g1, b1, g2, b2;
    logic signed [17:0] e1, e2;
  } aic_row_t;
  aic_row_t rows [5] = '{
    '{2'h0, 12'h800, 12'h800, 16'h03E8, 16'h0000, 16'h07D0, 16'h0000, 18'sh001F4, 18'sh003E8},
    '{2'h1, 12'h000, 12'h733, 16'h03E8, -16'sh0064, 16'h0640, 16'h0000, -18'sh00064, 18'sh001F4},
    '{2'h2, 12'h400, 12'h000, 16'h044C, 16'h0064, 16'h0BB8, 16'h03E8, 18'sh00258, 18'sh003E8},
    '{2'h3, 12'hC00, 12'h320, 16'h03E8, 16'h0000, 16'h2710, -16'sh03E8, -18'sh001F4, -18'sh003E8},
    '{2'h0, 12'h800, 12'h000, 16'h2710, 16'h0000, 16'h0000, 16'h2710, 18'sh01388, 18'sh02710}};
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [ADR_W-1:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = '0, wb_dat_o, rd;
  logic wb_ack_o, cur = 1'b0, cur_in;
  logic [RAW_W-1:0] lvl1 = '0, lvl2 = '0, code1, code2;
  logic signed [OUT_W-1:0] ch1_value_o, ch2_value_o, aux_freq_o;
  logic [NUM_USES-1:0] ch2_use_o;
  int err_count = 0, cmp_count = 0;
  always #5 clk_i = ~clk_i;
  aic_source_model aic_source_model_inst (.clk_i(clk_i), .level_one_i(lvl1),
    .level_two_i(lvl2), .current_i(cur), .code_one_o(code1), .code_two_o(code2),
    .current_o(cur_in));
  aic_top aic_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .analog_channel_one_i(code1), .analog_channel_two_i(code2),
    .voltage_current_selector_i(cur_in), .ch1_value_o(ch1_value_o),
    .ch2_value_o(ch2_value_o), .aux_freq_o(aux_freq_o), .ch2_use_o(ch2_use_o));
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk_val(input string nm, input logic [17:0] exp, input logic [17:0] got);
    chk_word(nm, {14'h0, exp}, {14'h0, got});
  endtask
  task automatic wb_xfer(input logic we, input logic [ADR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= SEL_FULL;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && n < 16) begin
      @(posedge clk_i);
      n++;
    end
    if (wb_ack_o !== 1'b1) begin
      err_count++;
      report_and_stop();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic rd_chk(input string nm, input logic [ADR_W-1:0] a, input logic [31:0] e);
    wb_xfer(1'b0, a, 32'h0);
    chk_word(nm, e, rd);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("gain1", OFS_CH1_GAIN, {16'h0, RST_GAIN});
    rd_chk("unmapped", 8'h40, 32'h0);
    foreach (rows[i]) begin
      wb_xfer(1'b1, OFS_INPUT_TYPE, {30'h0, rows[i].ty});
      wb_xfer(1'b1, OFS_CH1_GAIN, {16'h0, rows[i].g1});
      wb_xfer(1'b1, OFS_CH1_BIAS, {{16{rows[i].b1[15]}}, rows[i].b1});
      wb_xfer(1'b1, OFS_CH2_GAIN, {16'h0, rows[i].g2});
      wb_xfer(1'b1, OFS_CH2_BIAS, {{16{rows[i].b2[15]}}, rows[i].b2});
      lvl1 <= rows[i].c1;
      lvl2 <= rows[i].c2;
      cur <= rows[i].ty[0];
      repeat (4) @(posedge clk_i);
      chk_val("ch1", rows[i].e1, ch1_value_o);
      chk_val("ch2", rows[i].e2, ch2_value_o);
      rd_chk("ch1 reg", OFS_CH1_OUT, {14'h0, rows[i].e1});
      rd_chk("ch2 reg", OFS_CH2_OUT, {14'h0, rows[i].e2});
      rd_chk("status", OFS_STATUS, {29'h0, cur, rows[i].ty[0], rows[i].ty[1]});
    end
    wb_xfer(1'b1, OFS_CH1_GAIN, 32'h0000FFFF);
    rd_chk("gain1", OFS_CH1_GAIN, 32'h00002710);
    wb_xfer(1'b1, OFS_CH1_BIAS, 32'hFFFFF830);
    rd_chk("bias1", OFS_CH1_BIAS, 32'hFFFFFC18);
    wb_xfer(1'b1, OFS_CH2_BIAS, 32'h00002AF8);
    rd_chk("bias2", OFS_CH2_BIAS, 32'h00002710);
    wb_xfer(1'b1, OFS_CH2_FILT, 32'h000000FF);
    rd_chk("tau2", OFS_CH2_FILT, {24'h0, TAU_MAX});
    for (int u = 0; u < NUM_USES; u++) begin
      wb_xfer(1'b1, OFS_CH2_FUNC, 32'(u));
      repeat (2) @(posedge clk_i);
      chk_val("use", 18'h00001 << u, ch2_use_o);
    end
    wb_xfer(1'b1, OFS_CH2_FUNC, 32'h00000012);
    rd_chk("use code", OFS_CH2_FUNC, 32'h00000011);
    wb_xfer(1'b1, OFS_CH2_FILT, 32'h0);
    wb_xfer(1'b1, OFS_CH2_BIAS, 32'h0);
    wb_xfer(1'b1, OFS_CH2_GAIN, 32'h000007D0);
    wb_xfer(1'b1, OFS_CH1_BIAS, 32'h0);
    wb_xfer(1'b1, OFS_CH2_FUNC, 32'h0);
    lvl1 <= 12'h000;
    lvl2 <= 12'h800;
    repeat (4) @(posedge clk_i);
    chk_val("aux", 18'sh003E8, aux_freq_o);
    // a 63 % step needs ~10 ms at tau 1, so only a partial rise is expected here
    wb_xfer(1'b1, OFS_CH1_FILT, 32'h00000001);
    lvl1 <= 12'h800;
    repeat (3 * TICK_CYC + 10) @(posedge clk_i);
    chk_val("ch1 rise", 18'h00001,
      {17'h0, ch1_value_o > 0 && ch1_value_o < 18'sh01388});
    chk_val("ch2 hold", 18'sh003E8, ch2_value_o);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk_val("ch1 reset", 18'h0, ch1_value_o);
    rd_chk("type reset", OFS_INPUT_TYPE, {30'h0, RST_TYPE});
    report_and_stop();
  end
endmodule // aic_top_test
`default_nettype wire
